// >>> common/clk_ctrl_pkg.sv
/*
  Constants, types and shared helpers of the clock source and divider control block.
  Assumes one core clock; RC and slow-clock activity arrive as synchronous ticks, the external clock as a synchronous level.
*/
// ============================================================================
package clk_ctrl_pkg;

   // ==========================================================================
   // register map and reset values
   localparam logic [15:0] DIV_CTRL_ADDR     = 16'hF002;
   localparam logic [15:0] SRC_CTRL_ADDR     = 16'hF003;
   localparam logic [7:0]  DIV_CTRL_RESET    = 8'h33;
   localparam logic [7:0]  SRC_CTRL_RESET    = 8'h03;

   // ==========================================================================
   // field positions
   localparam int          CPU_DIV_LSB       = 0;
   localparam int          FAST_SRC_MODE_BIT = 2;
   localparam int          OUT_DIV_LSB       = 4;
   localparam int          CPU_SEL_BIT       = 0;
   localparam int          FAST_OSC_EN_BIT   = 1;
   localparam int          DOUBLE_EN_BIT     = 2;
   localparam int          SRC_CTRL_ZERO_BIT = 7;

   // ==========================================================================
   // counts
   localparam int          RC_START_PULSES   = 128;
   localparam int          DIV_CNT_W         = 5;
   localparam logic [3:0]  DIV_WRAP_POINT    = 4'hF;   // all divided clocks fall together here
   localparam logic [2:0]  SLOW_EDGE_POINT   = 3'h7;   // doubled-slow edge every 8 oscillator edges

   typedef enum logic [1:0] {
      DIV_BY_1 = 2'h0,
      DIV_BY_2 = 2'h1,
      DIV_BY_4 = 2'h2,
      DIV_BY_8 = 2'h3
   } div_sel_t;

   // bit n of the edge counter is the oscillator clock divided by 2**n
   function automatic logic divTap(input logic [DIV_CNT_W-1:0] cnt, input div_sel_t sel);
      return cnt[sel];
   endfunction

endpackage

// >>> common/osc_if.sv
/*
  Bundle between the register front end, the oscillator start gate and the divider.
  Assumes all members are synchronous to the core clock.
*/
`timescale 1ns/1ns
interface osc_if;
   logic enable;   // oscillator enabled by software
   logic rcMode;   // internal RC source selected
   logic tick;     // one oscillator clock edge, one-cycle pulse
   logic running;  // oscillator clock being supplied

   modport ctrl (output enable, output rcMode, input running);
   modport gen  (input enable, input rcMode, output tick, output running);
   modport div  (input tick);
endinterface

// >>> src/clock_divider_select.sv
/*
  Divider chain of the oscillator clock with boundary-aligned divider selection.
  Assumes one oscillator edge per tick pulse on the bundle.
*/
`timescale 1ns/1ns
module clock_divider_select
   import clk_ctrl_pkg::*;
(
   input  wire logic     core_clk,   // core clock
   input  wire logic     rstSync_n,  // synchronised reset, active low
   input  wire logic     clkEn,      // freezes state while low
   osc_if.div            oscBus,     // oscillator edges
   input  wire div_sel_t cpuDivSel,  // requested fast divider
   input  wire div_sel_t outDivSel,  // requested port divider
   output logic          fastLvl,    // divided fast clock level
   output logic          outLvl,     // divided port clock level
   output logic          slowEdge    // doubled-slow edge for crystal-less parts
);
   logic [DIV_CNT_W-1:0] cnt_q;
   logic [DIV_CNT_W-1:0] cnt_d;
   div_sel_t             cpuSel_q;
   div_sel_t             outSel_q;
   logic                 atWrap;

   // ==========================================================================
   // a new ratio is taken only where every tap falls at once, so no runt pulse
   assign atWrap = oscBus.tick && (cnt_q[3:0] == DIV_WRAP_POINT);
   assign cnt_d  = oscBus.tick ? cnt_q + 5'h01 : cnt_q;

   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         cnt_q    <= '0;
         cpuSel_q <= div_sel_t'(DIV_CTRL_RESET[CPU_DIV_LSB +: 2]);
         outSel_q <= div_sel_t'(DIV_CTRL_RESET[OUT_DIV_LSB +: 2]);
      end else if (clkEn) begin
         cnt_q <= cnt_d;
         if (atWrap) begin
            cpuSel_q <= cpuDivSel;
            outSel_q <= outDivSel;
         end
      end
   end

   // tapped levels, registered together with the counter
   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         fastLvl  <= 1'b0;
         outLvl   <= 1'b0;
         slowEdge <= 1'b0;
      end else if (clkEn) begin
         fastLvl  <= divTap(cnt_d, atWrap ? cpuDivSel : cpuSel_q);
         outLvl   <= divTap(cnt_d, atWrap ? outDivSel : outSel_q);
         slowEdge <= oscBus.tick && (cnt_q[2:0] == SLOW_EDGE_POINT);
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstSync_n);

   a_fast_tap_bit: assert property (fastLvl == cnt_q[cpuSel_q])
      else $error("fast clock not the selected counter tap");
   a_out_tap_bit: assert property (outLvl == cnt_q[outSel_q])
      else $error("port clock not the selected counter tap");
   a_sel_at_boundary: assert property (
      !$stable(cpuSel_q) || !$stable(outSel_q) |-> cnt_q[3:0] == 4'h0 && $past(cnt_q[3:0]) == DIV_WRAP_POINT)
      else $error("divider ratio changed away from a boundary");
endmodule

// >>> src/clock_source_divider_control.sv
/*
  Clock source and divider control: two control registers, oscillator start gating,
  fast and port clock division, slow and doubled slow clocks, cpu clock selection.
  Assumes register strobes and tick inputs are synchronous to core_clk; produced
  clocks are levels sampled on core_clk.
*/
`timescale 1ns/1ns
module clock_source_divider_control
   import clk_ctrl_pkg::*;
#(
   parameter bit CRYSTAL_LESS = 1'b0   // part without slow crystal or external clock
) (
   input  wire logic        core_clk,       // core clock, 100 MHz
   input  wire logic        reset_n,        // asynchronous reset, active low
   input  wire logic        clkEn,          // freezes all state while low
   input  wire logic [15:0] regAddr,        // register address
   input  wire logic [15:0] regWrData,      // register write data
   input  wire logic        regWrite,       // write strobe
   input  wire logic        regRead,        // read strobe
   input  wire logic        regWord,        // 16-bit access
   output logic      [15:0] regRdData,      // read data, cycle after strobe
   input  wire logic        rcTick,         // one RC oscillator edge
   input  wire logic        extClkPin,      // external fast clock level
   input  wire logic        slowTick,       // one doubled-slow-clock edge from crystal
   output logic             slowClk,        // slow time-base clock
   output logic             slowClkDouble,  // doubled slow clock
   output logic             fastClk,        // fast time-base clock
   output logic             cpuClkSelect,   // cpu system clock
   output logic             portOutClk      // fast output clock for the port
);

   // ==========================================================================
   // reset release
   logic rstMeta_q;
   logic rstSync_n;

   // two stages keep a late release from reaching the logic metastable
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_q <= 1'b0;
         rstSync_n <= 1'b0;
      end else if (clkEn) begin
         rstMeta_q <= 1'b1;
         rstSync_n <= rstMeta_q;
      end
   end

   // ==========================================================================
   // control registers
   logic [7:0] divCtrl_q;
   logic [7:0] divCtrl_d;
   logic [7:0] srcCtrl_q;
   logic [7:0] srcCtrl_d;
   logic       wrDiv;
   logic       wrSrc;
   logic [7:0] srcWrByte;

   // a word access at the first address covers both registers
   assign wrDiv     = regWrite && (regAddr == DIV_CTRL_ADDR);
   assign wrSrc     = regWrite && (((regAddr == SRC_CTRL_ADDR) && !regWord)
                                 || ((regAddr == DIV_CTRL_ADDR) && regWord));
   assign srcWrByte = regWord ? regWrData[15:8] : regWrData[7:0];

   // next divider register: the source bit is locked while the oscillator is on
   always_comb begin
      divCtrl_d = regWrData[7:0];
      if (srcCtrl_q[FAST_OSC_EN_BIT]) begin
         divCtrl_d[FAST_SRC_MODE_BIT] = divCtrl_q[FAST_SRC_MODE_BIT];
      end
      if (CRYSTAL_LESS) begin
         divCtrl_d[FAST_SRC_MODE_BIT] = 1'b0;
      end
   end

   // next source register: a stopped oscillator cannot be the cpu clock
   always_comb begin
      srcCtrl_d = srcWrByte;
      srcCtrl_d[SRC_CTRL_ZERO_BIT] = 1'b0;
      if (CRYSTAL_LESS) begin
         srcCtrl_d[FAST_OSC_EN_BIT] = 1'b1;
         srcCtrl_d[CPU_SEL_BIT]     = 1'b1;
      end
      srcCtrl_d[CPU_SEL_BIT] = srcCtrl_d[CPU_SEL_BIT] & srcCtrl_d[FAST_OSC_EN_BIT];
   end

   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         divCtrl_q <= DIV_CTRL_RESET;
      end else if (clkEn && wrDiv) begin
         divCtrl_q <= divCtrl_d;
      end
   end

   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         srcCtrl_q <= SRC_CTRL_RESET;
      end else if (clkEn && wrSrc) begin
         srcCtrl_q <= srcCtrl_d;
      end
   end

   // read data stand for one cycle only; unmapped addresses read zero
   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         regRdData <= 16'h0000;
      end else if (clkEn) begin
         regRdData <= 16'h0000;
         if (regRead) begin
            if (regAddr == DIV_CTRL_ADDR) begin
               regRdData <= regWord ? {srcCtrl_q, divCtrl_q} : {8'h00, divCtrl_q};
            end else if ((regAddr == SRC_CTRL_ADDR) && !regWord) begin
               regRdData <= {8'h00, srcCtrl_q};
            end
         end
      end
   end

   // ==========================================================================
   // oscillator and divider chain
   osc_if oscBus ();

   assign oscBus.enable = srcCtrl_q[FAST_OSC_EN_BIT];
   assign oscBus.rcMode = !divCtrl_q[FAST_SRC_MODE_BIT];

   osc_start_gate #(
      .START_PULSES (RC_START_PULSES)
   ) u_start (
      .core_clk  (core_clk),
      .rstSync_n (rstSync_n),
      .clkEn     (clkEn),
      .rcTick    (rcTick),
      .extClkPin (extClkPin),
      .oscBus    (oscBus)
   );

   logic divSlowEdge;

   // the same divided clock serves cpu path and peripherals
   clock_divider_select u_div (
      .core_clk  (core_clk),
      .rstSync_n (rstSync_n),
      .clkEn     (clkEn),
      .oscBus    (oscBus),
      .cpuDivSel (div_sel_t'(divCtrl_q[CPU_DIV_LSB +: 2])),
      .outDivSel (div_sel_t'(divCtrl_q[OUT_DIV_LSB +: 2])),
      .fastLvl   (fastClk),
      .outLvl    (portOutClk),
      .slowEdge  (divSlowEdge)
   );

   // ==========================================================================
   // slow and doubled slow clocks
   logic slowPhase_q;
   logic slowSrcEdge;

   // without a crystal the slow clock is the fast oscillator divided by sixteen
   assign slowSrcEdge = CRYSTAL_LESS ? divSlowEdge : slowTick;

   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         slowPhase_q   <= 1'b0;
         slowClk       <= 1'b0;
         slowClkDouble <= 1'b0;
      end else if (clkEn) begin
         if (slowSrcEdge) begin
            slowPhase_q <= ~slowPhase_q;
            if (slowPhase_q) slowClk <= ~slowClk;
         end
         if (!srcCtrl_q[DOUBLE_EN_BIT]) begin
            slowClkDouble <= 1'b0;
         end else if (slowSrcEdge) begin
            slowClkDouble <= ~slowClkDouble;
         end
      end
   end

   // ==========================================================================
   // cpu clock selection
   logic cpuSelAct_q;
   logic switchOk;
   logic selNow;

   // switch while both sources are low; a stopped oscillator releases at once
   assign switchOk = !oscBus.running || (!cpuClkSelect && !fastClk && !slowClk);
   assign selNow   = switchOk ? srcCtrl_q[CPU_SEL_BIT] : cpuSelAct_q;

   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         cpuSelAct_q  <= SRC_CTRL_RESET[CPU_SEL_BIT];
         cpuClkSelect <= 1'b0;
      end else if (clkEn) begin
         cpuSelAct_q  <= selNow;
         cpuClkSelect <= selNow ? fastClk : slowClk;
      end
   end

   // ==========================================================================
   // checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstSync_n);

   a_reset_div_value: assert property (
      $rose(rstSync_n) |-> divCtrl_q == DIV_CTRL_RESET && srcCtrl_q == SRC_CTRL_RESET)
      else $error("control registers not at reset values");
   a_mode_locked_on: assert property (
      clkEn && srcCtrl_q[FAST_OSC_EN_BIT] |=> $stable(divCtrl_q[FAST_SRC_MODE_BIT]))
      else $error("source mode changed while oscillator enabled");
   a_sel_needs_osc: assert property (
      !srcCtrl_q[FAST_OSC_EN_BIT] |-> !srcCtrl_q[CPU_SEL_BIT])
      else $error("fast cpu clock selected with oscillator off");
   a_crystal_less_fixed: assert property (
      CRYSTAL_LESS |-> srcCtrl_q[1:0] == 2'h3 && !divCtrl_q[FAST_SRC_MODE_BIT])
      else $error("crystal-less part left fixed settings");
   a_src_read_back: assert property (
      clkEn && regRead && regAddr == SRC_CTRL_ADDR && !regWord
      |=> regRdData == {8'h00, $past(srcCtrl_q)}) else $error("source register read wrong");
   a_word_write_pair: assert property (
      !CRYSTAL_LESS && clkEn && regWrite && regWord && regAddr == DIV_CTRL_ADDR && !srcCtrl_q[FAST_OSC_EN_BIT]
      |=> divCtrl_q == $past(regWrData[7:0]) && srcCtrl_q[FAST_OSC_EN_BIT] == $past(regWrData[9]))
      else $error("word write did not reach both registers");
   a_double_off_low: assert property (
      clkEn && !srcCtrl_q[DOUBLE_EN_BIT] |=> !slowClkDouble)
      else $error("doubled slow clock runs while disabled");

   c_mode_to_external: cover property (!divCtrl_q[FAST_SRC_MODE_BIT] ##1 divCtrl_q[FAST_SRC_MODE_BIT]);
   c_cpu_to_slow: cover property (cpuSelAct_q ##1 !cpuSelAct_q);
   c_word_read: cover property (regRead && regWord && regAddr == DIV_CTRL_ADDR);
endmodule

// >>> src/osc_start_gate.sv
/*
  Oscillator start gate: holds off the RC oscillator clock until it has settled; the external clock is supplied at once.
  Assumes rcTick and extClkPin are synchronous to core_clk.
*/
`timescale 1ns/1ns
module osc_start_gate
   import clk_ctrl_pkg::*;
#(
   parameter int START_PULSES = RC_START_PULSES
) (
   input  wire logic core_clk,   // core clock
   input  wire logic rstSync_n,  // synchronised reset, active low
   input  wire logic clkEn,      // freezes state while low
   input  wire logic rcTick,     // one RC oscillator edge
   input  wire logic extClkPin,  // external fast clock level
   osc_if.gen        oscBus      // oscillator bundle
);
   typedef enum logic [1:0] {OSC_OFF = 2'h0, OSC_WARM = 2'h1, OSC_RUN = 2'h2} osc_state_t;
   osc_state_t state_q;
   logic [7:0] pulseCnt_q;
   logic       extPrev_q;
   logic       extEdge;

   // ==========================================================================
   // both edges of the external pin count as oscillator edges
   assign extEdge        = extClkPin ^ extPrev_q;
   assign oscBus.running = (state_q == OSC_RUN);
   assign oscBus.tick    = oscBus.running && (oscBus.rcMode ? rcTick : extEdge);

   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         extPrev_q <= 1'b0;
      end else if (clkEn) begin
         extPrev_q <= extClkPin;
      end
   end

   // warm-up sequencer; external clock needs no settling
   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state_q    <= OSC_OFF;
         pulseCnt_q <= 8'h00;
      end else if (clkEn) begin
         if (!oscBus.enable) begin
            state_q    <= OSC_OFF;
            pulseCnt_q <= 8'h00;
         end else begin
            unique case (state_q)
               OSC_OFF:  state_q <= oscBus.rcMode ? OSC_WARM : OSC_RUN;
               OSC_WARM: if (rcTick) begin
                  if (pulseCnt_q == 8'(START_PULSES - 1)) state_q <= OSC_RUN;
                  pulseCnt_q <= pulseCnt_q + 8'h01;
               end
               OSC_RUN:  state_q <= OSC_RUN;
               default:  state_q <= OSC_OFF;
            endcase
         end
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstSync_n);

   a_warm_done_run: assert property (
      clkEn && oscBus.enable && state_q == OSC_WARM && rcTick && pulseCnt_q == 8'(START_PULSES - 1)
      |=> state_q == OSC_RUN) else $error("oscillator not supplied after warm-up count");
   a_no_early_run: assert property (
      state_q == OSC_WARM && !(rcTick && pulseCnt_q == 8'(START_PULSES - 1)) |=> state_q != OSC_RUN)
      else $error("oscillator supplied before warm-up count");
   c_warm_to_run: cover property (state_q == OSC_WARM ##1 state_q == OSC_RUN);
endmodule

// >>> verif/clock_source_divider_control_bench.sv
/*
  Self-checking bench of the clock source and divider control block.
  Assumes the source model drives the oscillator inputs; clkEn stays high throughout.
*/
`timescale 1ns/1ns
module clock_source_divider_control_bench;
   import clk_ctrl_pkg::*;
   localparam int RC_GAP  = 4;
   localparam int EXT_GAP = 6;
   localparam int SLOW_GAP = 20;

   logic        core_clk, reset_n, regWrite, regRead, regWord;
   logic [15:0] regAddr, regWrData, regRdData;
   logic        rcTick, extClkPin, slowTick;
   logic        slowClk, slowClkDouble, fastClk, cpuClkSelect, portOutClk;
   int          mismatches, n_compared, ticks, w, per;
   logic [7:0]  div, r;

   osc_source_model #(.RC_GAP(RC_GAP), .EXT_GAP(EXT_GAP), .SLOW_GAP(SLOW_GAP)) i_osc_source_model (
      .core_clk(core_clk), .rcTick(rcTick), .extClkPin(extClkPin), .slowTick(slowTick));

   clock_source_divider_control i_clock_source_divider_control (
      .core_clk(core_clk), .reset_n(reset_n), .clkEn(1'b1), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regWord(regWord),
      .regRdData(regRdData), .rcTick(rcTick), .extClkPin(extClkPin), .slowTick(slowTick),
      .slowClk(slowClk), .slowClkDouble(slowClkDouble), .fastClk(fastClk),
      .cpuClkSelect(cpuClkSelect), .portOutClk(portOutClk));

   // ==========================================================================
   // clock and watchdog; the whole run needs well under 10000 cycles
   always #5 core_clk = ~core_clk;

   initial begin
      #200000;
      mismatches++;
      tally_and_finish();
   end

   // ==========================================================================
   // expectations
   function automatic int expPer(input int code, input int gap);
      return gap << (code + 1);  // counter bit n toggles every 2**n edges
   endfunction

   function automatic logic [7:0] expDiv(input logic [7:0] cur, input logic [7:0] d);
      return (d & 8'hFB) | (cur & 8'h04);  // source bit held while oscillator runs
   endfunction

   // ==========================================================================
   // bus tasks; a spare cycle after each strobe keeps drives one per time step
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic wd);
      regAddr <= a;
      regWrData <= d;
      regWord <= wd;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rdchk(input string what, input logic [15:0] a, input logic wd, input logic [15:0] exp);
      logic [15:0] q;
      regAddr <= a;
      regWord <= wd;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 q = regRdData;
      check(what, q, exp);
      @(posedge core_clk);
   endtask

   // cycles between two rising edges (0 fast, 1 port, 2 slow, 3 doubled slow); the opening wait spans
   // sixteen of the slowest oscillator edges, so a divider change pending until the wrap has landed
   task automatic period(input int which, output int cyc);
      logic prv, cur;
      int n;
      cur = 1'b1;
      repeat (16 * EXT_GAP + 8) @(posedge core_clk);
      for (int e = 0; e < 4; e++) begin
         n = 0;
         do begin
            prv = cur;
            @(posedge core_clk);
            #1 cur = (which == 3) ? slowClkDouble : (which == 2) ? slowClk : (which == 1) ? portOutClk : fastClk;
            n++;
         end while (!(cur === 1'b1 && prv === 1'b0) && n < 1000);
         cyc = n;
      end
      @(posedge core_clk);
   endtask

   // cpu clock repeats the chosen source one cycle later
   task automatic follow(input bit fast, input int n);
      logic prv;
      #1 prv = fast ? fastClk : slowClk;
      repeat (n) begin
         @(posedge core_clk);
         #1 check("cpu clock", {15'h0, cpuClkSelect}, {15'h0, prv});
         check("double slow", {15'h0, slowClkDouble}, 16'h0);
         prv = fast ? fastClk : slowClk;
      end
      @(posedge core_clk);
   endtask

   task automatic tally_and_finish();
      if (mismatches == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ==========================================================================
   // main sequence
   initial begin
      core_clk = 1'b0;
      reset_n = 1'b0;
      {regWrite, regRead, regWord} = 3'h0;
      regAddr = 16'h0000;
      regWrData = 16'h0000;
      mismatches = 0;
      n_compared = 0;
      void'($urandom(98943));
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      // warm-up: RC edges are held off before the clock is supplied
      ticks = 0;
      w = 0;
      while (fastClk !== 1'b1 && w < 3000) begin
         @(posedge core_clk);
         #1 ticks += (rcTick === 1'b1);
         w++;
      end
      check("warm ticks", 16'(ticks >= 136 && ticks <= 137), 16'h1);
      @(posedge core_clk);
      rdchk("div reset", DIV_CTRL_ADDR, 1'b0, 16'h0033);
      rdchk("src reset", SRC_CTRL_ADDR, 1'b0, 16'h0003);
      rdchk("word reset", DIV_CTRL_ADDR, 1'b1, 16'h0333);
      rdchk("unmapped", 16'hF004, 1'b0, 16'h0000);
      rdchk("word odd", SRC_CTRL_ADDR, 1'b1, 16'h0000);
      period(1'b0, per);
      check("fast reset", 16'(per), 16'(expPer(3, RC_GAP)));
      follow(1'b1, 100);
      // every divider code, random spare bits, opposite code on the port clock
      div = DIV_CTRL_RESET;
      for (int c = 0; c < 4; c++) begin
         r = 8'($urandom);
         r = {r[7:6], 2'(3 - c), r[3:2], 2'(c)};
         wr(DIV_CTRL_ADDR, {8'h00, r}, 1'b0);
         div = expDiv(div, r);
         rdchk("div write", DIV_CTRL_ADDR, 1'b0, {8'h00, div});
         period(1'b0, per);
         check("fast div", 16'(per), 16'(expPer(c, RC_GAP)));
         period(1'b1, per);
         check("port div", 16'(per), 16'(expPer(3 - c, RC_GAP)));
      end
      wr(16'hF010, 16'h00FF, 1'b0);
      rdchk("after unmapped", DIV_CTRL_ADDR, 1'b0, {8'h00, div});
      // switch to the external source the proper way
      wr(SRC_CTRL_ADDR, 16'h0000, 1'b0);
      rdchk("src off", SRC_CTRL_ADDR, 1'b0, 16'h0000);
      repeat (100) @(posedge core_clk);
      follow(1'b0, 100);
      wr(SRC_CTRL_ADDR, 16'h0001, 1'b0);
      rdchk("sel forced", SRC_CTRL_ADDR, 1'b0, 16'h0000);
      wr(DIV_CTRL_ADDR, 16'h0004, 1'b0);
      rdchk("mode unlocked", DIV_CTRL_ADDR, 1'b0, 16'h0004);
      wr(SRC_CTRL_ADDR, 16'h0003, 1'b0);
      period(1'b0, per);
      check("ext fast", 16'(per), 16'(expPer(0, EXT_GAP)));
      wr(DIV_CTRL_ADDR, 16'h0000, 1'b0);
      rdchk("mode locked", DIV_CTRL_ADDR, 1'b0, 16'h0004);
      // back to RC and oscillator on in one word, then a word write that tries the locked mode bit
      wr(SRC_CTRL_ADDR, 16'h0000, 1'b0);
      wr(DIV_CTRL_ADDR, 16'h0333, 1'b1);
      rdchk("word on", DIV_CTRL_ADDR, 1'b1, 16'h0333);
      wr(DIV_CTRL_ADDR, 16'h03C5, 1'b1);
      rdchk("word write", DIV_CTRL_ADDR, 1'b1, 16'h03C1);
      wr(SRC_CTRL_ADDR, 16'h00FF, 1'b0);
      rdchk("src top bit", SRC_CTRL_ADDR, 1'b0, 16'h007F);
      // slow clock toggles every second crystal edge, doubled clock on every edge once enabled
      period(2, per);
      check("slow clk", 16'(per), 16'(SLOW_GAP * 4));
      period(3, per);
      check("double slow on", 16'(per), 16'(SLOW_GAP * 2));
      tally_and_finish();
   end
endmodule

// >>> verif/osc_source_model.sv
/*
  Stand-in for the clock sources: RC oscillator edge pulses, external clock level and
  doubled-slow crystal edge pulses.
  Assumes core_clk is the only clock; every output changes just after its rising edge.
*/
`timescale 1ns/1ns
module osc_source_model #(
   parameter int RC_GAP   = 4,   // cycles per RC edge
   parameter int EXT_GAP  = 6,   // cycles per external edge
   parameter int SLOW_GAP = 20   // cycles per doubled-slow edge
) (
   input  wire logic core_clk,   // core clock
   output logic      rcTick,     // RC edge pulse
   output logic      extClkPin,  // external clock level
   output logic      slowTick    // doubled-slow edge pulse
);
   // ==========================================================================
   // free-running sources; the design's gate decides when edges count
   int cnt;

   initial begin
      cnt = 0;
      rcTick = 1'b0;
      extClkPin = 1'b0;
      slowTick = 1'b0;
   end

   // external edges slower than core clock by far keeps the rated limit
   always @(posedge core_clk) begin
      cnt <= cnt + 1;
      rcTick <= (cnt % RC_GAP) == 0;
      slowTick <= (cnt % SLOW_GAP) == 0;
      if ((cnt % EXT_GAP) == 0) begin
         extClkPin <= ~extClkPin;
      end
   end
endmodule
